// file: design/bctr_consts.svh
// Register offsets, field positions, reset values and sizes of the trace recorder
`ifndef BCTR_CONSTS_SVH
`define BCTR_CONSTS_SVH
`define BCTR_OFF_CTRL 8'h00
`define BCTR_OFF_STAT 8'h04
`define BCTR_OFF_DELAY 8'h08
`define BCTR_OFF_RDIDX 8'h0c
`define BCTR_OFF_RDADDR 8'h10
`define BCTR_OFF_RDDATA 8'h14
`define BCTR_OFF_RDINFO 8'h18
`define BCTR_OFF_COUNT 8'h1c
`define BCTR_CTRL_DLYEN 0
`define BCTR_CTRL_CLEAR 1
`define BCTR_CTRL_IMODE 2
`define BCTR_STAT_RUN 0
`define BCTR_STAT_DLY 1
`define BCTR_STAT_WRAP 2
`define BCTR_CTRL_RST 32'h0000_0000
`define BCTR_DELAY_RST 16'h0000
`define BCTR_AW 22
`endif

// file: design/bctr_pkg.sv
// Types of the bus cycle trace recorder
`default_nettype none
package bctr_pkg;
  typedef enum logic [1:0] {BCTR_SZ_BYTE, BCTR_SZ_WORD, BCTR_SZ_LONG} bctr_size_t;
  typedef enum logic [1:0] {BCTR_DIR_NONE, BCTR_DIR_READ, BCTR_DIR_WRITE} bctr_dir_t;
  typedef enum logic [3:0] {
    BCTR_ST_DMA, BCTR_ST_XFER, BCTR_ST_DBG, BCTR_ST_DATA, BCTR_ST_FETCH,
    BCTR_ST_SLP_DMA, BCTR_ST_SLP_XFER, BCTR_ST_SLP_DBG, BCTR_ST_SLEEP,
    BCTR_ST_ALL_MODULE_CLOCK_STOP_STOP, BCTR_ST_NONE
  } bctr_state_t;
  typedef enum logic [3:0] {
    BCTR_AR_EXT16, BCTR_AR_EXT8, BCTR_AR_EMU_WIDE, BCTR_AR_EMU_NARROW, BCTR_AR_ROM,
    BCTR_AR_FLASH, BCTR_AR_IO16, BCTR_AR_IO8, BCTR_AR_RAM, BCTR_AR_XRAM_WIDE,
    BCTR_AR_NONE
  } bctr_area_t;
  typedef enum logic [1:0] {BCTR_IDLE, BCTR_RUN, BCTR_DELAY} bctr_fsm_t;
endpackage : bctr_pkg
`default_nettype wire

// file: design/bctr_mem.sv
// Trace memory: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module bctr_mem #(
  parameter int AW = 22,
  parameter int DW = 80
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(2**AW)-1];

  // Memory holds no reset; entries are meaningful only below the fill count
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : bctr_mem
`default_nettype wire

// file: design/bctr_top.sv
// Bus cycle trace recorder with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "bctr_consts.svh"
// Summary of operation
// (R1) With no conditions, every bus cycle is captured unfiltered, fill-until-stop.
// (R2) Capture starts when the user program starts running.
// (R3) Capture stops when the user program halts.
// (R4) Newest entry reads as index zero; older entries get negative indices.
// (R5) With stop delay, stop-condition cycle is zero; later cycles count positive.
// (R6) Each entry stores address, data and byte, word or longword size.
// (R7) Each entry stores direction: read, write or none.
// (R8) Each entry stores a validity flag; zero means valid cycle.
// (R9) Each entry stores the operating state class of the cycle.
// (R10) Each entry stores the accessed area class of the cycle.
// (R11) Mode zero records the single mask bit; marked unused in mode two.
// (R12) Trace memory holds about four million entries.
// (R13) When memory is full, the oldest entry is overwritten.
module bctr_top #(
  parameter int AW = `BCTR_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Monitored bus, one cycle per bus_strobe_i pulse, same clock
  input wire logic prog_run_i,
  input wire logic stop_cond_i,
  input wire logic bus_strobe_i,
  input wire logic [23:0] bus_addr_i,
  input wire logic [31:0] bus_data_i,
  input wire logic [1:0] bus_size_i,
  input wire logic [1:0] bus_dir_i,
  input wire logic cycle_valid_flag_i,
  input wire logic [3:0] bus_state_i,
  input wire logic [3:0] bus_area_i,
  input wire logic condition_interrupt_mask_bit_i,
  input wire logic [2:0] ext_mask_level_i,
  output logic prog_halt_req_o,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  localparam int DW = 80;

  bctr_pkg::bctr_fsm_t st_q, st_d;
  logic [AW-1:0] wptr_q, wptr_d;
  logic [AW:0] fill_q, fill_d;
  logic wrap_q, wrap_d;
  logic [AW-1:0] zero_ptr_q, zero_ptr_d;
  logic [15:0] dly_cnt_q, dly_cnt_d;
  logic [15:0] post_q, post_d;
  logic halt_q, halt_d;
  logic run_prev_q;
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] delay_q, delay_d;
  logic [31:0] rdidx_q, rdidx_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic wr_en;
  logic [DW-1:0] entry;
  logic [DW-1:0] rd_entry;
  logic [AW-1:0] raddr;
  logic run_start;
  logic cap;

  // Entry layout: addr, data, size, dir, valid, state, area, mode-0 bit, mode-2 level
  always_comb begin
    entry = {bus_addr_i, bus_data_i, bus_size_i, bus_dir_i, // R6 R7
             cycle_valid_flag_i,                            // R8
             bus_state_i, bus_area_i,                       // R9 R10
             // Mode-0 bit reads as one when mode-two levels are recorded
             (ctrl_q[`BCTR_CTRL_IMODE] ? 1'b1 : condition_interrupt_mask_bit_i), // R11
             (ctrl_q[`BCTR_CTRL_IMODE] ? ext_mask_level_i : 3'h0),
             // Six spare bits fill the info word so the address sits at the top
             ctrl_q[`BCTR_CTRL_IMODE], 6'h00};
  end

  assign run_start = prog_run_i && !run_prev_q;
  // No filter: every strobed cycle is taken while tracing is live
  assign cap = bus_strobe_i && (st_q != bctr_pkg::BCTR_IDLE); // R1
  assign wr_en = cap && ce_i;

  // Capture state machine
  always_comb begin
    st_d = st_q;
    wptr_d = wptr_q;
    fill_d = fill_q;
    wrap_d = wrap_q;
    zero_ptr_d = zero_ptr_q;
    dly_cnt_d = dly_cnt_q;
    post_d = post_q;
    halt_d = 1'b0;
    unique case (st_q)
      bctr_pkg::BCTR_IDLE: begin
        if (run_start) begin
          st_d = bctr_pkg::BCTR_RUN; // R2
          post_d = 16'h0000;
        end
      end
      bctr_pkg::BCTR_RUN: begin
        if (!prog_run_i) begin
          st_d = bctr_pkg::BCTR_IDLE; // R3
        end else if (stop_cond_i && bus_strobe_i) begin
          zero_ptr_d = wptr_q; // R5
          if (ctrl_q[`BCTR_CTRL_DLYEN] && delay_q != 16'h0000) begin
            st_d = bctr_pkg::BCTR_DELAY;
            dly_cnt_d = delay_q;
          end else begin
            halt_d = 1'b1;
          end
        end
      end
      bctr_pkg::BCTR_DELAY: begin
        if (!prog_run_i) begin
          st_d = bctr_pkg::BCTR_IDLE; // R3
        end else if (bus_strobe_i) begin
          post_d = post_q + 16'h0001; // R5
          dly_cnt_d = dly_cnt_q - 16'h0001;
          if (dly_cnt_q == 16'h0001) begin
            halt_d = 1'b1;
            st_d = bctr_pkg::BCTR_IDLE;
          end
        end
      end
    endcase
    if (cap) begin
      // Pointer wraps so the oldest entry is replaced first
      wptr_d = wptr_q + 1'b1; // R13 R12
      if (fill_q == (AW+1)'(2**AW)) begin
        wrap_d = 1'b1;
      end else begin
        fill_d = fill_q + 1'b1;
      end
    end
    if (run_start && ctrl_q[`BCTR_CTRL_CLEAR]) begin
      wptr_d = '0;
      fill_d = '0;
      wrap_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= bctr_pkg::BCTR_IDLE;
      wptr_q <= '0;
      fill_q <= '0;
      wrap_q <= 1'b0;
      zero_ptr_q <= '0;
      dly_cnt_q <= 16'h0000;
      post_q <= 16'h0000;
      halt_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      wptr_q <= wptr_d;
      fill_q <= fill_d;
      wrap_q <= wrap_d;
      zero_ptr_q <= zero_ptr_d;
      dly_cnt_q <= dly_cnt_d;
      post_q <= post_d;
      halt_q <= halt_d;
      run_prev_q <= prog_run_i;
    end
  end

  assign prog_halt_req_o = halt_q;

  // Index 0 is newest, or the stop cycle when a delay ran; signed offset
  always_comb begin
    if (post_q != 16'h0000) begin
      raddr = zero_ptr_q + rdidx_q[AW-1:0]; // R5
    end else begin
      raddr = wptr_q - 1'b1 + rdidx_q[AW-1:0]; // R4
    end
  end

  bctr_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(wr_en),
    .waddr_i(wptr_q),
    .wdata_i(entry),
    .raddr_i(raddr),
    .rdata_o(rd_entry)
  );

  // Wishbone slave: ack one cycle after the request, dropped next cycle
  always_comb begin
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    rdidx_d = rdidx_q;
    dat_d = dat_q;
    ack_d = 1'b0;
    if (cyc_i && stb_i && !ack_q) begin
      ack_d = 1'b1;
      dat_d = 32'h0000_0000;
      unique case (adr_i)
        `BCTR_OFF_CTRL: dat_d = ctrl_q;
        `BCTR_OFF_STAT: dat_d = {29'h0, wrap_q, st_q == bctr_pkg::BCTR_DELAY,
                                 st_q != bctr_pkg::BCTR_IDLE};
        `BCTR_OFF_DELAY: dat_d = {16'h0000, delay_q};
        `BCTR_OFF_RDIDX: dat_d = rdidx_q;
        `BCTR_OFF_RDADDR: dat_d = {8'h00, rd_entry[79:56]};
        `BCTR_OFF_RDDATA: dat_d = rd_entry[55:24];
        `BCTR_OFF_RDINFO: dat_d = {8'h00, rd_entry[23:0]};
        `BCTR_OFF_COUNT: dat_d = {{(31-AW){1'b0}}, fill_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    // Write lands on the edge where the master samples ack, not on the request edge
    if (cyc_i && stb_i && we_i && ack_q) begin
      unique case (adr_i)
        `BCTR_OFF_CTRL: ctrl_d = {29'h0, dat_i[2:0]};
        `BCTR_OFF_DELAY: delay_d = dat_i[15:0];
        `BCTR_OFF_RDIDX: rdidx_d = dat_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `BCTR_CTRL_RST;
      delay_q <= `BCTR_DELAY_RST;
      rdidx_q <= 32'h0000_0000;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      delay_q <= delay_d;
      rdidx_q <= rdidx_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;

  // Checks
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ce_i && st_q == bctr_pkg::BCTR_IDLE && run_start |=> st_q == bctr_pkg::BCTR_RUN)
    else $error("trace did not start with program");
  AST_STOP: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && !prog_run_i |=> st_q == bctr_pkg::BCTR_IDLE)
    else $error("trace did not stop with program");
  AST_ALL: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    ce_i && bus_strobe_i && st_q != bctr_pkg::BCTR_IDLE |=> wptr_q == $past(wptr_q) + 1'b1)
    else $error("cycle not captured");
  AST_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && st_q == bctr_pkg::BCTR_IDLE && !run_start |=> $stable(wptr_q))
    else $error("capture while idle");
  AST_DELAY: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && st_q == bctr_pkg::BCTR_DELAY && bus_strobe_i && prog_run_i
    |=> post_q == $past(post_q) + 16'h0001)
    else $error("post index not advanced");
  AST_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    post_q == 16'h0000 && rdidx_q == 32'h0 |-> raddr == wptr_q - 1'b1)
    else $error("index zero not newest");
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    ce_i && cap && fill_q == (AW+1)'(2**AW) |=> wrap_q && fill_q == $past(fill_q))
    else $error("overwrite not flagged");
  AST_MASK: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ctrl_q[`BCTR_CTRL_IMODE] |-> entry[10] && entry[6])
    else $error("mode zero bit not marked unused");
  // Register bus handshake
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cyc_i && stb_i && !ack_q |=> ack_q ##1 !ack_q || !ce_i)
    else $error("ack timing wrong");

  // Stop point and halt request
  AST_ZPTR: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && st_q == bctr_pkg::BCTR_RUN && prog_run_i && stop_cond_i && bus_strobe_i
    |=> zero_ptr_q == $past(wptr_q))
    else $error("stop cycle not marked as index zero");
  AST_HALT_NOW: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    ce_i && st_q == bctr_pkg::BCTR_RUN && prog_run_i && stop_cond_i && bus_strobe_i
    && !ctrl_q[`BCTR_CTRL_DLYEN] |=> halt_q)
    else $error("halt not requested at stop cycle");
  AST_HALT_DLY: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && st_q == bctr_pkg::BCTR_DELAY && prog_run_i && bus_strobe_i
    && dly_cnt_q == 16'h0001 |=> halt_q && st_q == bctr_pkg::BCTR_IDLE)
    else $error("halt not requested after stop delay");
  // Memory bookkeeping
  AST_FILL: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    ce_i && cap && fill_q != (AW+1)'(2**AW) |=> fill_q == $past(fill_q) + 1'b1)
    else $error("fill count not advanced");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ce_i && run_start && ctrl_q[`BCTR_CTRL_CLEAR] |=> fill_q == '0 && !wrap_q)
    else $error("trace memory not emptied at start");

  // Coverage of the main scenarios
  COV_STOP: cover property (@(posedge clk_i) st_q == bctr_pkg::BCTR_RUN ##1
    st_q == bctr_pkg::BCTR_IDLE);
  COV_DELAY: cover property (@(posedge clk_i) st_q == bctr_pkg::BCTR_DELAY ##1 halt_q);
  COV_WRAP: cover property (@(posedge clk_i) $rose(wrap_q));
  COV_MODE2: cover property (@(posedge clk_i) wr_en && ctrl_q[`BCTR_CTRL_IMODE]);
endmodule : bctr_top
`default_nettype wire

// file: bench/bctr_cpu_model.sv
// Model of the monitored CPU bus that feeds the trace recorder
`timescale 1ns/1ps
`default_nettype none
module bctr_cpu_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic [7:0] dly_i,
  input wire logic slow_i,
  input wire logic halt_i,
  output logic run_o,
  output logic stb_o,
  output logic stop_o,
  output logic [23:0] adr_o,
  output logic [31:0] dat_o,
  output logic [16:0] inf_o
);
  integer seed = 32'h39fdbea0;
  logic [72:0] h[$];
  logic [72:0] e;
  logic gap = 1'b0;
  int cnt = 0;
  initial {run_o, stb_o, stop_o, adr_o, dat_o, inf_o} = '0;
  function automatic int rnd(input int m);
    return int'($unsigned($random(seed)) % m);
  endfunction : rnd
  // Idle address and data lines flip every cycle so a stale capture cannot pass; halt ends the program
  always @(posedge clk_i) begin
    stb_o <= 1'b0;
    stop_o <= 1'b0;
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
    gap <= slow_i & ~gap;
    if (!go_i) begin
      run_o <= 1'b0;
      cnt = 0;
    end else if (halt_i) begin
      run_o <= 1'b0;
    end else if (!run_o && cnt == 0) begin
      run_o <= 1'b1;
      h.delete();
    end else if (run_o && !gap && cnt <= int'(n_i) + int'(dly_i)) begin
      e = {24'($random(seed)), 32'($random(seed)), 2'(rnd(3)), 2'(rnd(3)), rnd(4) == 0,
           4'(rnd(11)), 4'(rnd(11)), 4'($random(seed))};
      {adr_o, dat_o, inf_o} <= e;
      stb_o <= 1'b1;
      stop_o <= (cnt == int'(n_i));
      h.push_back(e);
      cnt++;
    end
  end
endmodule : bctr_cpu_model
`default_nettype wire

// file: bench/bctr_top_tb.sv
// Self-checking bench of the bus cycle trace recorder
`timescale 1ns/1ps
`default_nettype none
`include "bctr_consts.svh"
module bctr_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, halt, run, bstb, stop;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [7:0] n = 8'h00;
  logic [7:0] dly = 8'h00;
  logic [23:0] badr;
  logic [31:0] bdat;
  logic [16:0] inf;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int bad_count = 0;
  int checked = 0;
  always #5 clk_i = ~clk_i;
  bctr_cpu_model bctr_cpu_model_inst (.clk_i(clk_i), .go_i(go), .n_i(n), .dly_i(dly),
    .slow_i(slow), .halt_i(halt), .run_o(run), .stb_o(bstb), .stop_o(stop), .adr_o(badr),
    .dat_o(bdat), .inf_o(inf));
  bctr_top #(.AW(4)) bctr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .prog_run_i(run), .stop_cond_i(stop), .bus_strobe_i(bstb), .bus_addr_i(badr),
    .bus_data_i(bdat), .bus_size_i(inf[16:15]), .bus_dir_i(inf[14:13]),
    .cycle_valid_flag_i(inf[12]), .bus_state_i(inf[11:8]), .bus_area_i(inf[7:4]),
    .condition_interrupt_mask_bit_i(inf[3]), .ext_mask_level_i(inf[2:0]),
    .prog_halt_req_o(halt), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  // Each read answer against the oldest expectation
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && eq.size() > 0) begin
      checked++;
      if ((dat_o & mq[0]) !== (eq[0] & mq[0])) begin
        bad_count++;
        $display("MISMATCH %0t adr %h got %h exp %h", $time, adr_i, dat_o, eq[0]);
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  // Single Wishbone cycle; a read notes its expected word and mask first
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    if (!w) begin
      eq.push_back(d);
      mq.push_back(m);
    end
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, a, d};
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge clk_i);
  endtask : wb
  // Reads back one entry; the index register needs two cycles to settle
  task automatic chk(input int i, input logic [72:0] e, input logic im);
    wb(1'b1, `BCTR_OFF_RDIDX, 32'(i), 32'h0);
    @(posedge clk_i);
    wb(1'b0, `BCTR_OFF_RDADDR, {8'h00, e[72:49]}, 32'hffffffff);
    wb(1'b0, `BCTR_OFF_RDDATA, e[48:17], 32'hffffffff);
    wb(1'b0, `BCTR_OFF_RDINFO, {8'h00, e[16:4], e[3] | im, (im ? e[2:0] : 3'h0), im, 6'h00},
       32'hffffffff);
  endtask : chk
  // Program runs until the recorder asks it to halt
  task automatic run_trace(input logic [2:0] c, input logic [7:0] d, input logic [7:0] k,
                           input logic s);
    int t;
    wb(1'b1, `BCTR_OFF_DELAY, 32'(d), 32'h0);
    wb(1'b1, `BCTR_OFF_CTRL, 32'(c), 32'h0);
    {n, dly, slow, go} <= {k, d, s, 1'b1};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (halt !== 1'b1 && t < 300);
    if (t >= 300) begin
      bad_count++;
      $display("MISMATCH %0t no halt request", $time);
    end
    go <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : run_trace
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("MISMATCH %0t timeout", $time);
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `BCTR_OFF_CTRL, `BCTR_CTRL_RST, 32'hffffffff);
    wb(1'b0, `BCTR_OFF_DELAY, 32'(`BCTR_DELAY_RST), 32'hffffffff);
    wb(1'b1, 8'h20, 32'hffffffff, 32'h0);
    wb(1'b0, 8'h20, 32'h0, 32'hffffffff);
    // Twenty prompt cycles overfill the sixteen entries
    run_trace(3'h2, 8'h00, 8'h13, 1'b0);
    wb(1'b0, `BCTR_OFF_STAT, 32'h4, 32'h5);
    for (int j = 0; j < 15; j++) chk(-j, bctr_cpu_model_inst.h[19 - j], 1'b0);
    // Slow program, stop delay of three, mode two mask recording
    run_trace(3'h7, 8'h03, 8'h09, 1'b1);
    wb(1'b0, `BCTR_OFF_STAT, 32'h0, 32'h5);
    for (int j = -5; j <= 3; j++) chk(j, bctr_cpu_model_inst.h[9 + j], 1'b1);
    results();
  end
endmodule : bctr_top_tb
`default_nettype wire
